// >>> tb/idd_dev_model.sv
// Purpose: Behavioural memory device that answers read commands.
// Assumes: Fixed read latency of CL cycles; pins sampled at the rising edge.
// Notes:   One flag stands for both the data and the strobe drivers.
`timescale 1ns/1ns
`default_nettype none
module idd_dev_model #(
  parameter int CL = 11
) (
  input  wire logic       clk,
  input  wire logic       cs_n,
  input  wire logic       ras_n,
  input  wire logic       cas_n,
  input  wire logic       we_n,
  input  wire logic       dq_oe,
  input  wire logic       dqs_oe,
  output logic [1:0]      dq_dev,
  output logic            dev_oe,
  output logic            clash
);
  logic [15:0] due = 16'h0000;
  logic        pat = 1'b0;
  logic        cur = 1'b0;
  logic        hit = 1'b0;
  int          j   = 0;
  wire logic   rd  = !cs_n && ras_n && !cas_n && we_n;
  assign clash = hit;
  always @(posedge clk) begin
    due <= {due[14:0], rd === 1'b1};
    hit <= hit || (dev_oe === 1'b1 && (dq_oe !== 1'b0 || dqs_oe !== 1'b0));
    if (due[CL - 1]) begin
      j <= 1;
      cur <= pat;
      pat <= ~pat;
      dq_dev <= 2'h0;
      dev_oe <= 1'b1;
    end else if (j > 0 && j < 4) begin
      j <= j + 1;
      dq_dev <= (cur && j[0]) ? 2'h3 : 2'h0;
    end else begin
      j <= 0;
      dev_oe <= 1'b0;
      // A released line must not keep its last value, so it toggles instead.
      dq_dev <= (dq_dev === 2'h1) ? 2'h2 : 2'h1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/idd_loop_seq_test.sv
// Purpose: Self-checking bench for the current-loop sequencer.
// Assumes: A short refresh cycle time so that the refresh loop wraps quickly.
// Notes:   Expected pins are worked out from the loop cycle count of the bench.
`timescale 1ns/1ns
`default_nettype none
module idd_loop_seq_test;
  localparam int NRFC = 40;
  logic        CLK = 1'b0;
  logic        RSTN = 1'b0;
  logic        RUN = 1'b0;
  logic [1:0]  LOOP_SEL = 2'h0;
  logic        CKE, CS_N, RAS_N, CAS_N, WE_N, ODT, DM, DQ_OE, DQS_OUT, DQS_OE, clash;
  logic [2:0]  BA;
  logic [15:0] ADDR;
  logic [1:0]  DQ_OUT;
  logic [6:0]  CYCLE;
  int          err_total = 0;
  int          samples_checked = 0;
  logic [31:0] seed = 32'h6EE02D71;
  idd_loop_seq #(.NRFC(NRFC)) dut_u (.CLK(CLK), .RSTN(RSTN), .RUN(RUN), .LOOP_SEL(LOOP_SEL),
    .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .ODT(ODT), .BA(BA),
    .ADDR(ADDR), .DM(DM), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .DQS_OUT(DQS_OUT),
    .DQS_OE(DQS_OE), .CYCLE(CYCLE));
  idd_dev_model dev_u (.clk(CLK), .cs_n(CS_N), .ras_n(RAS_N), .cas_n(CAS_N), .we_n(WE_N),
    .dq_oe(DQ_OE), .dqs_oe(DQS_OE), .dq_dev(), .dev_oe(), .clash(clash));
  always #2 CLK = ~CLK;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Packs CS_N, RAS_N, CAS_N, WE_N, ODT, bank and address bits 6:3.
  function automatic logic [11:0] exp_pins(input int m, input int c);
    int         k;
    logic [3:0] cmd;
    k = (c == 0) ? 0 : c - 1;
    if (m == 2) begin
      if (c == 0) return 12'h100;
      cmd = (k % 4 < 2) ? 4'h8 : 4'hF;
      return {cmd, 1'b0, 3'(k / 4), (k % 4 < 2) ? 4'h0 : 4'hF};
    end
    cmd = (c % 4 == 0) ? ((m == 1) ? 4'h4 : 4'h5) : ((c % 4 == 1) ? 4'h8 : 4'hF);
    return {cmd, m == 1, 3'(c / 8), (c % 8 >= 4) ? 4'hF : 4'h0};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Modes 2 and 3 both select refresh; the choice between them is random.
  task automatic run_loop(input int m, input int n);
    int c, len, oe, ones, w;
    len = (m == 2) ? NRFC : 64;
    LOOP_SEL = (m == 2) ? 2'(2 + rnd() % 2) : 2'(m);
    RUN = 1'b1;
    w = 0;
    while (!(CS_N === 1'b0 && CYCLE === 7'h00) && w < 10) begin
      @(negedge CLK);
      w++;
    end
    check(w < 10, 1, "loop start");
    c = 0;
    oe = 0;
    ones = 0;
    for (int i = 0; i < n; i++) begin
      check({CS_N, RAS_N, CAS_N, WE_N, ODT, BA, ADDR[6:3]}, exp_pins(m, c), "command");
      check({CKE, DM, CYCLE}, {2'h2, 7'(c)}, "cke mask cycle");
      check({clash, (m == 1) ? 2'h0 : {DQ_OE, DQS_OE}}, 3'h0, "undriven");
      if (m == 1 && i >= 64 && i < 128) begin
        oe += DQ_OE && DQS_OE && DQS_OUT;
        ones += (DQ_OUT == 2'h3);
      end
      // Selection changes while running must be ignored.
      if (rnd() % 16 == 0) LOOP_SEL = 2'(rnd());
      c = (c + 1) % len;
      @(negedge CLK);
    end
    if (m == 1) begin
      check(oe, 64, "write bursts");
      check(ones, 16, "write pattern");
    end
    RUN = 1'b0;
    // A WR issued just before the stop still drains its burst for about fourteen cycles.
    repeat (8) @(negedge CLK);
    for (int i = 0; i < 8; i++) begin
      check(CS_N, 1, "idle deselect");
      @(negedge CLK);
    end
    check({DQ_OE, DQS_OE}, 2'h0, "bursts drained");
  endtask
  initial begin
    repeat (12) @(negedge CLK);
    check({CKE, CS_N}, 2'h3, "reset pins");
    RSTN = 1'b1;
    run_loop(0, 140);
    run_loop(1, 140);
    run_loop(2, 130);
    for (int r = 0; r < 6; r++) run_loop(rnd() % 3, 130 + rnd() % 70);
    give_verdict();
  end
  initial begin
    #60000;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire

// >>> verilog/idd_loop_params.svh
// Purpose: Constants for the burst current-loop stimulus sequencer.
// Assumes: One command per CLK cycle; pins are registered in the top module.
// Notes:   Types live in idd_loop_pkg.
// Notes on behaviour
// - Clock enable held high every cycle.
// - Write loop like read, ODT high, patterns alternate.
// - Eight sub-loops, bank steps 0..7, 64 cycles.
// - Refresh loop opens with REF, then a bank sweep with the address toggling.
// - Data mask held low in burst loops.
// - Read strobe undriven by controller.
// - Write strobe driven only for write bursts.
// - Write data driven per write burst.
// - Data lines undriven outside bursts.
// - Refresh loop: mask low, strobe and data undriven.
`ifndef IDD_LOOP_PARAMS_SVH
`define IDD_LOOP_PARAMS_SVH
`define IDD_BURST_LOOP_LEN   7'h40
`define IDD_SUBLOOP_LEN      4'h8
`define IDD_FILLER_LEN       3'h4
`define IDD_NRFC_DEFAULT     260
`define IDD_NCWL_DEFAULT     8
`define IDD_BURST_BEATS      8
`define IDD_PATTERN_A        8'h00
`define IDD_PATTERN_B        8'h33
`define IDD_ADDR_HIGH_NIBBLE 4'hF
`endif

// >>> verilog/idd_loop_pkg.sv
// Purpose: Types for the burst current-loop stimulus sequencer.
// Assumes: Nothing beyond the params header.
// Notes:   One-hot loop selection states.
package idd_loop_pkg;
  typedef enum logic [3:0] {
    LOOP_IDLE    = 4'h1,
    LOOP_READ    = 4'h2,
    LOOP_WRITE   = 4'h4,
    LOOP_REFRESH = 4'h8
  } loop_state_e;
  typedef logic [1:0] loop_sel_t;
endpackage

// >>> verilog/idd_loop_seq.sv
// Purpose: Drives DDR3 command pins with the burst read, write and refresh loops.
// Assumes: LOOP_SEL may change while running, it is taken only from idle; CLK equals the memory clock.
// Notes:   DQ/DQS enables low mean the pin rests at mid-level termination.
`timescale 1ns/1ns
`default_nettype none
`include "idd_loop_params.svh"
module idd_loop_seq #(
  parameter int NRFC = `IDD_NRFC_DEFAULT,
  parameter int NCWL = `IDD_NCWL_DEFAULT
) (
  input  wire logic       CLK,
  input  wire logic       RSTN,
  input  wire logic       RUN,
  input  wire logic [1:0] LOOP_SEL,
  output logic            CKE,
  output logic            CS_N,
  output logic            RAS_N,
  output logic            CAS_N,
  output logic            WE_N,
  output logic            ODT,
  output logic [2:0]      BA,
  output logic [15:0]     ADDR,
  output logic            DM,
  output logic [1:0]      DQ_OUT,
  output logic            DQ_OE,
  output logic            DQS_OUT,
  output logic            DQS_OE,
  output logic [6:0]      CYCLE
);
  // The REF and one full bank sweep need 33 cycles; the check rejects anything below 34.
  if (NRFC < 34 || NRFC > 1023) begin : g_bad_nrfc
    $error("NRFC out of range");
  end
  if (NCWL < 1 || NCWL > 29) begin : g_bad_ncwl
    $error("NCWL out of range");
  end
  idd_loop_pkg::loop_state_e state;
  logic [9:0] cnt;
  logic [9:0] next_cnt;
  logic [9:0] last_cnt;
  logic [9:0] fill;
  logic       wr_go;
  logic [7:0] wr_pat;
  logic       wr_active;
  logic [1:0] wr_beat;
  logic [2:0] sub;
  logic [2:0] ph;
  logic [5:0] quiet;
  // Cycles from a WR on the pins to the first data beat on the pins.
  localparam int WR_LAG = NCWL + 2;

  // The selection is taken only from idle, so a change in mid-loop waits for RUN low.
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state <= idd_loop_pkg::LOOP_IDLE;
    end else if (!RUN) begin
      state <= idd_loop_pkg::LOOP_IDLE;
    end else begin
      case (state)
        idd_loop_pkg::LOOP_IDLE: begin
          if (LOOP_SEL == 2'h0) state <= idd_loop_pkg::LOOP_READ;
          else if (LOOP_SEL == 2'h1) state <= idd_loop_pkg::LOOP_WRITE;
          else state <= idd_loop_pkg::LOOP_REFRESH;
        end
        default: state <= state;
      endcase
    end
  end

  always_comb begin
    if (state == idd_loop_pkg::LOOP_REFRESH) last_cnt = 10'(NRFC - 1);
    else last_cnt = 10'(`IDD_BURST_LOOP_LEN) - 10'h1;
    if (state == idd_loop_pkg::LOOP_IDLE || cnt == last_cnt) next_cnt = 10'h0;
    else next_cnt = cnt + 10'h1;
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) cnt <= 10'h0;
    else cnt <= next_cnt;
  end

  assign sub  = cnt[5:3];
  assign ph   = cnt[2:0];
  assign fill = cnt - 10'h1;

  // The refresh filler counts from cnt minus one so that its bank sweep starts after REF.
  // Command, bank and address; CKE fixed high from reset on.
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      CKE <= 1'b1;
      {CS_N, RAS_N, CAS_N, WE_N} <= 4'h8;
      ODT <= 1'b0;
      BA <= 3'h0;
      ADDR <= 16'h0000;
      DM <= 1'b0;
    end else begin
      CKE <= 1'b1;
      DM  <= 1'b0;
      case (state)
        idd_loop_pkg::LOOP_READ, idd_loop_pkg::LOOP_WRITE: begin
          BA   <= sub;
          ODT  <= (state == idd_loop_pkg::LOOP_WRITE);
          ADDR <= {9'h000, ph[2] ? `IDD_ADDR_HIGH_NIBBLE : 4'h0, 3'h0};
          if (ph[1:0] == 2'h0) begin
            if (state == idd_loop_pkg::LOOP_WRITE) {CS_N, RAS_N, CAS_N, WE_N} <= 4'h4;
            else {CS_N, RAS_N, CAS_N, WE_N} <= 4'h5;
          end else if (ph[1:0] == 2'h1) {CS_N, RAS_N, CAS_N, WE_N} <= 4'h8;
          else {CS_N, RAS_N, CAS_N, WE_N} <= 4'hF;
        end
        idd_loop_pkg::LOOP_REFRESH: begin
          ODT <= 1'b0;
          if (cnt == 10'h0) begin
            {CS_N, RAS_N, CAS_N, WE_N} <= 4'h1;
            BA   <= 3'h0;
            ADDR <= 16'h0000;
          end else begin
            BA   <= fill[4:2];
            ADDR <= {9'h000, fill[1] ? `IDD_ADDR_HIGH_NIBBLE : 4'h0, 3'h0};
            {CS_N, RAS_N, CAS_N, WE_N} <= fill[1] ? 4'hF : 4'h8;
          end
        end
        default: begin
          {CS_N, RAS_N, CAS_N, WE_N} <= 4'h8;
          ODT  <= 1'b0;
          BA   <= 3'h0;
          ADDR <= 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) CYCLE <= 7'h00;
    else CYCLE <= cnt[6:0];
  end

  assign wr_go  = (state == idd_loop_pkg::LOOP_WRITE) && (ph[1:0] == 2'h0);
  assign wr_pat = ph[2] ? `IDD_PATTERN_B : `IDD_PATTERN_A;

  // Latency counts from the command register stage, one cycle after cnt.
  idd_write_beats #(.CWL(NCWL + 1)) u_beats (
    .clk     (CLK),
    .rstn    (RSTN),
    .start   (wr_go),
    .pattern (wr_pat),
    .active  (wr_active),
    .beat    (wr_beat)
  );

  // DQS_OUT only marks the driven window; the toggling is left to the pad logic.
  // That keeps this block on a single clock at the cost of a plain strobe level.
  // Read and refresh data come from the device or rest at mid-level.
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      DQ_OUT <= 2'h0;
      DQ_OE <= 1'b0;
      DQS_OUT <= 1'b0;
      DQS_OE <= 1'b0;
    end else begin
      DQ_OE   <= wr_active;
      DQ_OUT  <= wr_beat;
      DQS_OE  <= wr_active;
      DQS_OUT <= wr_active;
    end
  end

  // Cycles since the last WR left the pins, saturating. Bursts still drain after RUN
  // drops, so the checks use this count rather than the loop state.
  always_ff @(posedge CLK) begin
    if (!RSTN) quiet <= 6'h3F;
    else if ({CS_N, RAS_N, CAS_N, WE_N} == 4'h4) quiet <= 6'h00;
    else if (quiet != 6'h3F) quiet <= quiet + 6'h01;
  end

  a_cke_high: assert property (@(posedge CLK) disable iff (!RSTN) CKE)
    else $error("CKE not high");
  a_dm_low: assert property (@(posedge CLK) disable iff (!RSTN) !DM)
    else $error("DM not low");
  a_rd_cmd: assert property (@(posedge CLK) disable iff (!RSTN)
    state == idd_loop_pkg::LOOP_READ && $stable(state) && ph == 3'h4 |=>
    {CS_N, RAS_N, CAS_N, WE_N} == 4'h5 && ADDR[6:3] == 4'hF
    ##1 {CS_N, RAS_N, CAS_N, WE_N} == 4'h8)
    else $error("read sequence wrong");
  a_wr_odt: assert property (@(posedge CLK) disable iff (!RSTN)
    state == idd_loop_pkg::LOOP_WRITE && $stable(state) |=> ODT)
    else $error("ODT low in write loop");
  a_wr_cmd: assert property (@(posedge CLK) disable iff (!RSTN)
    state == idd_loop_pkg::LOOP_WRITE && $stable(state) && ph == 3'h0 |=>
    {CS_N, RAS_N, CAS_N, WE_N} == 4'h4 && ADDR[6:3] == 4'h0 && ODT)
    else $error("write command wrong");
  a_wr_burst: assert property (@(posedge CLK) disable iff (!RSTN)
    {CS_N, RAS_N, CAS_N, WE_N} == 4'h4 |-> ##WR_LAG (DQ_OE && DQS_OE && DQS_OUT) [*4])
    else $error("write burst not driven");
  a_wr_data: assert property (@(posedge CLK) disable iff (!RSTN)
    {CS_N, RAS_N, CAS_N, WE_N} == 4'h4 && ADDR[6:3] == 4'hF |->
    ##WR_LAG DQ_OUT == 2'h0 ##1 DQ_OUT == 2'h3 ##1 DQ_OUT == 2'h0 ##1 DQ_OUT == 2'h3)
    else $error("write pattern wrong");
  a_bank_step: assert property (@(posedge CLK) disable iff (!RSTN)
    state != idd_loop_pkg::LOOP_IDLE && state != idd_loop_pkg::LOOP_REFRESH && cnt == 10'h038
    && $stable(state) |=> BA == 3'h7)
    else $error("bank not 7 at cycle 56");
  a_ref_cmd: assert property (@(posedge CLK) disable iff (!RSTN)
    state == idd_loop_pkg::LOOP_REFRESH && cnt == 10'h000 && $stable(state) |=>
    {CS_N, RAS_N, CAS_N, WE_N} == 4'h1 && !ODT && BA == 3'h0)
    else $error("refresh command wrong");
  a_ref_fill: assert property (@(posedge CLK) disable iff (!RSTN)
    state == idd_loop_pkg::LOOP_REFRESH && cnt == 10'h005 && $stable(state) |=>
    BA == 3'h1 && CS_N)
    else $error("refresh filler bank wrong");
  a_loop_wrap: assert property (@(posedge CLK) disable iff (!RSTN)
    state == idd_loop_pkg::LOOP_READ && cnt == 10'h03F && RUN |=> cnt == 10'h000)
    else $error("loop did not wrap");
  a_dq_quiet: assert property (@(posedge CLK) disable iff (!RSTN)
    int'(quiet) > NCWL + 4 |-> !DQ_OE)
    else $error("data driven outside write burst");
  a_dqs_read: assert property (@(posedge CLK) disable iff (!RSTN)
    int'(quiet) > NCWL + 4 |-> !DQS_OE)
    else $error("strobe driven without burst");

  // Main scenarios the bench is expected to reach.
  c_read: cover property (@(posedge CLK) state == idd_loop_pkg::LOOP_READ && cnt == 10'h03F);
  c_write: cover property (@(posedge CLK) DQ_OE && ODT);
  c_ref: cover property (@(posedge CLK) state == idd_loop_pkg::LOOP_REFRESH && cnt == last_cnt);
  c_drain: cover property (@(posedge CLK) state == idd_loop_pkg::LOOP_IDLE && DQ_OE);
endmodule
`default_nettype wire

// >>> verilog/idd_write_beats.sv
// Purpose: Shifts write-burst data and strobe timing for the data pins.
// Assumes: start pulses one cycle per write command; pattern is one byte.
// Notes:   Two bits per CLK cycle as a double-rate pair.
`timescale 1ns/1ns
`default_nettype none
`include "idd_loop_params.svh"
module idd_write_beats #(
  parameter int CWL = `IDD_NCWL_DEFAULT
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic [7:0] pattern,
  output logic            active,
  output logic [1:0]      beat
);
  // The delay line below is 32 stages deep, which bounds the latency that can be served.
  if (CWL < 1 || CWL > 30) begin : g_bad_cwl
    $error("CWL out of range");
  end
  logic [31:0] dly_go;
  logic [7:0]  dly_pat [0:31];
  logic [7:0]  shreg;
  logic [2:0]  left;
  always_ff @(posedge clk) begin
    if (!rstn) dly_go <= '0;
    else dly_go <= {dly_go[30:0], start};
  end
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_pat
      if (g == 0) begin : g_head
        always_ff @(posedge clk) begin
          if (!rstn) dly_pat[g] <= 8'h00;
          else dly_pat[g] <= pattern;
        end
      end else begin : g_tail
        always_ff @(posedge clk) begin
          if (!rstn) dly_pat[g] <= 8'h00;
          else dly_pat[g] <= dly_pat[g-1];
        end
      end
    end
  endgenerate
  // Burst of eight beats spans four cycles once write latency expires.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shreg  <= 8'h00;
      left   <= 3'h0;
      active <= 1'b0;
      beat   <= 2'h0;
    end else if (dly_go[CWL-1]) begin
      shreg  <= {dly_pat[CWL-1][5:0], 2'h0};
      left   <= 3'h3;
      active <= 1'b1;
      beat   <= dly_pat[CWL-1][7:6];
    end else if (left != 3'h0) begin
      shreg  <= {shreg[5:0], 2'h0};
      left   <= left - 3'h1;
      beat   <= shreg[7:6];
    end else begin
      active <= 1'b0;
      beat   <= 2'h0;
    end
  end
endmodule
`default_nettype wire
